// ==== hdl/cccr_cfg.svh ====
`ifndef CCCR_CFG_SVH
`define CCCR_CFG_SVH
// register indices; byte address is four times the index
`define CCCR_IDX_GLOBAL 8'h06
`define CCCR_IDX_CH0_CONF 8'h09
`define CCCR_IDX_CH0_OTH 8'h0A
`define CCCR_IDX_CH0_OTL 8'h0B
`define CCCR_IDX_CH0_GTH 8'h0C
`define CCCR_IDX_CH0_GTL 8'h0D
`define CCCR_IDX_CH1_CONF 8'h0E
`define CCCR_IDX_CH1_OTH 8'h0F
`define CCCR_IDX_CH1_OTL 8'h10
`define CCCR_IDX_MOD_DIV 8'h20
`define CCCR_IDX_SETTLE 8'h21
// global register fields
`define CCCR_BIT_AUX_EN 14
`define CCCR_BIT_AUX_LVL 13
`define CCCR_DLY_HI 12
`define CCCR_DLY_LO 9
`define CCCR_BIT_CHOP_EN 8
`define CCCR_GLOBAL_WMASK 16'h7F00
// channel config fields
`define CCCR_PHASE_HI 15
`define CCCR_PHASE_LO 6
`define CCCR_CH_CFG_WMASK 16'hFFC3
`define CCCR_LOW_WMASK 16'hFF00
// reset values
`define CCCR_RST_GLOBAL 16'h0600
`define CCCR_RST_ZERO 16'h0000
`define CCCR_RST_GAIN_HI 16'h8000
`define CCCR_RST_MOD_DIV 16'h0001
// settle delay base: 2 periods at code 0
`define CCCR_SETTLE_BASE 17'h00002
`endif

// ==== hdl/cccr_pkg.sv ====
package cccr_pkg;
   typedef enum logic [1:0] {
      CCCR_MUX_PAIR = 2'b00,
      CCCR_MUX_SHORT = 2'b01,
      CCCR_MUX_DC = 2'b10,
      CCCR_MUX_AC = 2'b11
   } cccr_mux_e;
   typedef enum logic [1:0] {
      CCCR_RD_IDLE = 2'b00,
      CCCR_RD_RESP = 2'b01
   } cccr_rd_e;
   typedef logic [15:0] cccr_word_t;
endpackage

// ==== hdl/cccr_settle_timer.sv ====
`include "cccr_cfg.svh"
// counts modulator periods of settling after chop start
module cccr_settle_timer (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_start,
   input wire logic i_mod_tick,
   input wire logic [3:0] i_code,
   output logic o_busy,
   output logic [16:0] o_periods
);
   logic [16:0] cnt_q, cnt_d;
   logic busy_q, busy_d;
   always_comb begin
      cnt_d = cnt_q;
      busy_d = busy_q;
      if (i_start) begin
         // 2 << code periods
         cnt_d = 17'(`CCCR_SETTLE_BASE << i_code);
         busy_d = 1'b1;
      end else if (busy_q && i_mod_tick) begin
         cnt_d = cnt_q - 17'h00001;
         if (cnt_q == 17'h00001) begin
            busy_d = 1'b0;
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= 17'h00000;
         busy_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
      end
   end
   assign o_busy = busy_q;
   assign o_periods = cnt_q;
endmodule

// ==== hdl/cccr_regs.sv ====
`include "cccr_cfg.svh"
// Contract
// - bit 14 set drives channel 2 positive input pin digitally; resets clear
// - while driving, pin level follows bit 13
// - 4-bit settle delay, reset 0011b, gives 2 << code modulator periods
// - bit 8 enables global chop; cleared at reset
// - channel config bits 15:6 hold signed phase delay, reset zero
// - input select 00 pair, 01 short, 10 dc, 11 ac diagnostic
// - channel 1 code 00 uses own positive and shared negative pin
// - 24-bit offset trim split high word and upper low byte; low byte zero
// - channel 0 gain trim 24-bit unsigned, split high and upper low byte
// - gain trim high resets to 8000h, low to zero
// - channel config bits 5:2 read zero always
module cccr_regs (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic i_chop_start,
   output logic o_aux_pin_out,
   output logic o_aux_pin_oe,
   output logic o_chop_global_enable,
   output logic o_chop_settling,
   output logic [9:0] o_ch0_phase_offset,
   output logic [1:0] o_ch0_input_select,
   output logic [23:0] o_ch0_offset_trim,
   output logic [23:0] o_ch0_gain_trim,
   output logic [9:0] o_ch1_phase_offset,
   output logic [1:0] o_ch1_input_select,
   output logic o_ch1_use_shared_neg,
   output logic [23:0] o_ch1_offset_trim
);
   localparam int NREG = 11;
   localparam logic [7:0] IDX [NREG] = '{`CCCR_IDX_GLOBAL,
      `CCCR_IDX_CH0_CONF, `CCCR_IDX_CH0_OTH, `CCCR_IDX_CH0_OTL,
      `CCCR_IDX_CH0_GTH, `CCCR_IDX_CH0_GTL, `CCCR_IDX_CH1_CONF,
      `CCCR_IDX_CH1_OTH, `CCCR_IDX_CH1_OTL, `CCCR_IDX_MOD_DIV,
      `CCCR_IDX_SETTLE};
   // writable masks: reserved read-only bits never store
   localparam logic [15:0] WMASK [NREG] = '{`CCCR_GLOBAL_WMASK,
      `CCCR_CH_CFG_WMASK, 16'hFFFF, `CCCR_LOW_WMASK,
      16'hFFFF, `CCCR_LOW_WMASK, `CCCR_CH_CFG_WMASK,
      16'hFFFF, `CCCR_LOW_WMASK, 16'hFFFF, 16'h0000};
   localparam logic [15:0] RSTV [NREG] = '{`CCCR_RST_GLOBAL,
      `CCCR_RST_ZERO, `CCCR_RST_ZERO, `CCCR_RST_ZERO,
      `CCCR_RST_GAIN_HI, `CCCR_RST_ZERO, `CCCR_RST_ZERO,
      `CCCR_RST_ZERO, `CCCR_RST_ZERO, `CCCR_RST_MOD_DIV,
      `CCCR_RST_ZERO};

   cccr_pkg::cccr_word_t reg_q [NREG];
   cccr_pkg::cccr_word_t reg_d [NREG];
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [7:0] aw_idx_q, aw_idx_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [15:0] div_q, div_d;
   logic tick_q, tick_d;
   logic aux_out_q, aux_out_d, aux_oe_q, aux_oe_d;
   logic settling_q, settling_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic arready_q, arready_d, shared_q, shared_d;
   logic do_write, w_hit, r_hit;
   logic [7:0] ar_idx;
   logic [3:0] w_sel, r_sel;
   logic timer_busy;
   logic [16:0] timer_left;

   // index addressing; address bits 9:2 give the index, bits 1:0 and bits above 9 ignored
   assign ar_idx = s_axi_araddr[9:2];
   assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

   always_comb begin
      w_hit = 1'b0;
      r_hit = 1'b0;
      w_sel = 4'h0;
      r_sel = 4'h0;
      for (int k = 0; k < NREG; k++) begin
         if (aw_idx_q == IDX[k]) begin
            w_hit = 1'b1;
            w_sel = 4'(k);
         end
         if (ar_idx == IDX[k]) begin
            r_hit = 1'b1;
            r_sel = 4'(k);
         end
      end
   end

   // write channel: address and data accepted in either order
   always_comb begin
      aw_hold_d = aw_hold_q;
      w_hold_d = w_hold_q;
      aw_idx_d = aw_idx_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && !aw_hold_q) begin
         aw_hold_d = 1'b1;
         aw_idx_d = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_hold_q) begin
         w_hold_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (do_write) begin
         aw_hold_d = 1'b0;
         w_hold_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = w_hit ? 2'b00 : 2'b10;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   // register storage, one per entry
   for (genvar g = 0; g < NREG; g++) begin : g_reg
      logic [15:0] wmask;
      always_comb begin
         wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & WMASK[g];
         reg_d[g] = reg_q[g];
         if (g == NREG - 1) begin
            // live settle count, read-only status
            reg_d[g] = timer_left[15:0];
         end else if (do_write && w_hit && w_sel == 4'(g)) begin
            // reserved bits masked so stray ones never take effect
            reg_d[g] = (reg_q[g] & ~wmask) | (wdata_q[15:0] & wmask);
         end
      end
      always_ff @(posedge i_core_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            reg_q[g] <= RSTV[g];
         end else begin
            reg_q[g] <= reg_d[g];
         end
      end
   end

   // read channel: one-cycle latency answer
   always_comb begin
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end else if (!rvalid_q && s_axi_arvalid) begin
         rvalid_d = 1'b1;
         rresp_d = r_hit ? 2'b00 : 2'b10;
         rdata_d = r_hit ? {16'h0000, reg_q[r_sel]} : 32'h00000000;
      end
   end

   // modulator tick from programmable divider, avoids a second clock
   always_comb begin
      div_d = div_q + 16'h0001;
      tick_d = 1'b0;
      if (div_q >= reg_q[9]) begin
         div_d = 16'h0000;
         tick_d = 1'b1;
      end
   end

   // pin and status outputs
   always_comb begin
      aux_oe_d = reg_q[0][`CCCR_BIT_AUX_EN];
      aux_out_d = aux_oe_d & reg_q[0][`CCCR_BIT_AUX_LVL];
      settling_d = timer_busy;
      // write readies follow next hold state, read ready follows next rvalid state, so the ports come from flops
      awready_d = !aw_hold_d;
      wready_d = !w_hold_d;
      arready_d = !rvalid_d;
      shared_d = reg_d[6][1:0] == cccr_pkg::CCCR_MUX_PAIR;
   end

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         aw_idx_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
         rvalid_q <= 1'b0;
         rresp_q <= 2'b00;
         rdata_q <= 32'h00000000;
         div_q <= 16'h0000;
         tick_q <= 1'b0;
         aux_out_q <= 1'b0;
         aux_oe_q <= 1'b0;
         settling_q <= 1'b0;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         arready_q <= 1'b1;
         shared_q <= 1'b1;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         aw_idx_q <= aw_idx_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
         div_q <= div_d;
         tick_q <= tick_d;
         aux_out_q <= aux_out_d;
         aux_oe_q <= aux_oe_d;
         settling_q <= settling_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         shared_q <= shared_d;
      end
   end

   cccr_settle_timer u_settle (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_start(i_chop_start && reg_q[0][`CCCR_BIT_CHOP_EN]),
      .i_mod_tick(tick_q),
      .i_code(reg_q[0][`CCCR_DLY_HI:`CCCR_DLY_LO]),
      .o_busy(timer_busy),
      .o_periods(timer_left)
   );

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign o_aux_pin_out = aux_out_q;
   assign o_aux_pin_oe = aux_oe_q;
   assign o_chop_global_enable = reg_q[0][`CCCR_BIT_CHOP_EN];
   assign o_chop_settling = settling_q;
   assign o_ch0_phase_offset = reg_q[1][`CCCR_PHASE_HI:`CCCR_PHASE_LO];
   assign o_ch0_input_select = reg_q[1][1:0];
   assign o_ch0_offset_trim = {reg_q[2], reg_q[3][15:8]};
   assign o_ch0_gain_trim = {reg_q[4], reg_q[5][15:8]};
   assign o_ch1_phase_offset = reg_q[6][`CCCR_PHASE_HI:`CCCR_PHASE_LO];
   assign o_ch1_input_select = reg_q[6][1:0];
   // shared negative pin only in normal pair mode
   assign o_ch1_use_shared_neg = shared_q;
   assign o_ch1_offset_trim = {reg_q[7], reg_q[8][15:8]};

   property p_aux_follow;
      @(posedge i_core_clk) disable iff (!i_nrst)
      1'b1 |=> o_aux_pin_oe == $past(reg_q[0][`CCCR_BIT_AUX_EN]);
   endproperty
   a_aux_follow: assert property (p_aux_follow)
      else $error("aux enable not followed");
   property p_aux_undriven;
      @(posedge i_core_clk) disable iff (!i_nrst)
      !o_aux_pin_oe |-> !o_aux_pin_out;
   endproperty
   a_aux_undriven: assert property (p_aux_undriven)
      else $error("aux pin level while undriven");
   property p_aux_level;
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_aux_pin_oe |-> o_aux_pin_out == $past(reg_q[0][`CCCR_BIT_AUX_LVL]);
   endproperty
   a_aux_level: assert property (p_aux_level)
      else $error("aux level wrong");
   property p_cfg_rsvd;
      @(posedge i_core_clk) disable iff (!i_nrst)
      reg_q[1][5:2] == 4'h0 && reg_q[6][5:2] == 4'h0;
   endproperty
   a_cfg_rsvd: assert property (p_cfg_rsvd)
      else $error("channel config reserved bits set");
   property p_low_rsvd;
      @(posedge i_core_clk) disable iff (!i_nrst)
      reg_q[3][7:0] == 8'h00 && reg_q[8][7:0] == 8'h00;
   endproperty
   a_low_rsvd: assert property (p_low_rsvd)
      else $error("offset low reserved byte set");
   property p_gain_low_rsvd;
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_ch0_gain_trim[7:0] == reg_q[5][15:8] && reg_q[5][7:0] == 8'h00;
   endproperty
   a_gain_low_rsvd: assert property (p_gain_low_rsvd)
      else $error("gain low byte wrong");
   property p_settle_len;
      @(posedge i_core_clk) disable iff (!i_nrst)
      i_chop_start && o_chop_global_enable |=>
         timer_left == 17'(`CCCR_SETTLE_BASE << $past(reg_q[0][12:9]));
   endproperty
   a_settle_len: assert property (p_settle_len)
      else $error("settle count wrong");
   property p_no_chop;
      @(posedge i_core_clk) disable iff (!i_nrst)
      !o_chop_global_enable && !timer_busy |=> !timer_busy;
   endproperty
   a_no_chop: assert property (p_no_chop)
      else $error("settle started with chop off");
   property p_shared;
      @(posedge i_core_clk) disable iff (!i_nrst)
      o_ch1_use_shared_neg |-> o_ch1_input_select == 2'b00;
   endproperty
   a_shared: assert property (p_shared)
      else $error("shared pin misuse");
   c_write: cover property (@(posedge i_core_clk) s_axi_bvalid);
   c_read: cover property (@(posedge i_core_clk) s_axi_rvalid);
   c_aux: cover property (@(posedge i_core_clk) o_aux_pin_oe);
   c_settle: cover property (@(posedge i_core_clk) $fell(timer_busy));
endmodule

// ==== test/cccr_regs_tb_top.sv ====
`include "cccr_cfg.svh"
module cccr_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int LIM = 100;
   localparam logic [7:0] IDX [9] = '{8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C,
      8'h0D, 8'h0E, 8'h0F, 8'h10};
   localparam logic [15:0] MSK [9] = '{16'h7F00, 16'hFFC3, 16'hFFFF,
      16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC3, 16'hFFFF, 16'hFF00};
   localparam logic [15:0] RST [9] = '{16'h0600, 16'h0000, 16'h0000,
      16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, i_chop_start = 1'b0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, o_aux_pin_out, o_aux_pin_oe, o_chop_global_enable;
   logic o_chop_settling, o_ch1_use_shared_neg;
   logic [1:0] s_axi_bresp, s_axi_rresp, o_ch0_input_select;
   logic [1:0] o_ch1_input_select;
   logic [31:0] s_axi_rdata;
   logic [9:0] o_ch0_phase_offset, o_ch1_phase_offset;
   logic [23:0] o_ch0_offset_trim, o_ch0_gain_trim, o_ch1_offset_trim;
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   logic [15:0] sh [9];
   int n_fail = 0;
   int checks = 0;
   int unsigned seed_v;

   cccr_regs u_cccr_regs (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .i_chop_start(i_chop_start),
      .o_aux_pin_out(o_aux_pin_out), .o_aux_pin_oe(o_aux_pin_oe),
      .o_chop_global_enable(o_chop_global_enable),
      .o_chop_settling(o_chop_settling),
      .o_ch0_phase_offset(o_ch0_phase_offset),
      .o_ch0_input_select(o_ch0_input_select),
      .o_ch0_offset_trim(o_ch0_offset_trim),
      .o_ch0_gain_trim(o_ch0_gain_trim),
      .o_ch1_phase_offset(o_ch1_phase_offset),
      .o_ch1_input_select(o_ch1_input_select),
      .o_ch1_use_shared_neg(o_ch1_use_shared_neg),
      .o_ch1_offset_trim(o_ch1_offset_trim));

   always #5 i_core_clk = ~i_core_clk;

   task automatic summarize;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic hang(input int n);
      if (n >= LIM) begin
         n_fail++;
         summarize();
      end
   endtask

   // address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
         input logic [1:0] rsp);
      int n;
      bit a, w, b;
      n = 0;
      a = 0;
      w = 0;
      b = 0;
      bq.push_back(rsp);
      @(posedge i_core_clk);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!b && n < LIM) begin
         @(posedge i_core_clk);
         n++;
         if (s_axi_awready && !a) begin
            a = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid) begin
            b = 1;
            s_axi_bready <= 1'b0;
         end
      end
      hang(n);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [33:0] exp);
      int n;
      bit a, r;
      n = 0;
      a = 0;
      r = 0;
      rq.push_back(exp);
      @(posedge i_core_clk);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r && n < LIM) begin
         @(posedge i_core_clk);
         n++;
         if (s_axi_arready && !a) begin
            a = 1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid) begin
            r = 1;
            s_axi_rready <= 1'b0;
         end
      end
      hang(n);
   endtask

   // responses are matched against the oldest note
   always @(posedge i_core_clk) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
         chk(s_axi_bresp, bq.pop_front());
      end
   end

   task automatic put(input int i, input logic [31:0] v);
      wr(IDX[i], v, 2'b00);
      sh[i] = v[15:0] & MSK[i];
      rd(IDX[i], {18'h0, sh[i]});
   endtask

   task automatic out_chk;
      repeat (2) @(posedge i_core_clk);
      chk(o_ch0_phase_offset, sh[1][15:6]);
      chk(o_ch0_input_select, sh[1][1:0]);
      chk(o_ch1_phase_offset, sh[6][15:6]);
      chk(o_ch1_input_select, sh[6][1:0]);
      chk(o_ch1_use_shared_neg, sh[6][1:0] == 2'b00);
      chk(o_ch0_offset_trim, {sh[2], sh[3][15:8]});
      chk(o_ch0_gain_trim, {sh[4], sh[5][15:8]});
      chk(o_ch1_offset_trim, {sh[7], sh[8][15:8]});
      chk(o_chop_global_enable, sh[0][8]);
      chk(o_aux_pin_oe, sh[0][14]);
      if (sh[0][14]) chk(o_aux_pin_out, sh[0][13]);
   endtask

   // settling length in cycles; zero if it never starts
   task automatic meas(output int c);
      int n;
      c = 0;
      n = 0;
      @(posedge i_core_clk);
      i_chop_start <= 1'b1;
      @(posedge i_core_clk);
      i_chop_start <= 1'b0;
      while (!o_chop_settling && n < 10) begin
         @(posedge i_core_clk);
         n++;
      end
      while (o_chop_settling && c < 300) begin
         @(posedge i_core_clk);
         c++;
      end
      if (c >= 300) hang(LIM);
   endtask

   initial begin
      int d0, d2, dx;
      seed_v = $urandom(32'hA4E6);
      repeat (8) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         sh[i] = RST[i];
         rd(IDX[i], {18'h0, RST[i]});
      end
      out_chk();
      repeat (3) begin
         for (int i = 0; i < 9; i++) begin
            // reserved global bits stay zero on the host side
            put(i, (i == 0) ? ($urandom & 32'h00007F00) : $urandom);
         end
         out_chk();
      end
      for (int m = 0; m < 4; m++) begin
         put(1, ($urandom & 32'h0000FFC0) | 32'(m));
         put(6, ($urandom & 32'h0000FFC0) | 32'(m));
         put(0, 32'(m) << 13);
         out_chk();
      end
      // unmapped places answer with an error and change nothing
      rd(8'h01, {2'b10, 32'h0});
      wr(8'h01, $urandom, 2'b10);
      wr(8'h3F, $urandom, 2'b10);
      for (int i = 0; i < 9; i++) rd(IDX[i], {18'h0, sh[i]});
      wr(8'h20, 32'h0, 2'b00);
      wr(IDX[0], 32'h0000_0100, 2'b00);
      meas(d0);
      chk(d0, 34'd2);
      wr(IDX[0], 32'h0000_0500, 2'b00);
      meas(d2);
      chk(d2 - d0, 34'd6);
      wr(IDX[0], 32'h0000_0400, 2'b00);
      meas(dx);
      chk(dx, 34'd0);
      summarize();
   end
endmodule
